// ---- wwd_pkg.sv ----
// Package for the windowed watchdog and clock monitor block.
// Assumes a single 20 MHz clock domain; no imports, use wwd_pkg::name.
package wwd_pkg;
   // Register map on the plain register port
   localparam logic [1:0] ADDR_SVC = 2'h0;   // service key register
   localparam logic [1:0] ADDR_CTL = 2'h1;   // control inputs from the core
   localparam logic [1:0] ADDR_STS = 2'h2;   // status, pending flag clear on write
   localparam logic [1:0] ADDR_TSEL = 2'h3;  // idle tick period select
   // Service key register fields
   localparam int SVC_WIN_LSB = 6;
   localparam int SVC_KEY_LSB = 1;
   localparam int SVC_CM_BIT = 0;
   localparam logic [4:0] SVC_KEY = 5'h0c;
   localparam logic [1:0] SVC_WIN_RST = 2'h3;
   localparam logic SVC_CM_RST = 1'b1;
   // Option bit that enables the watchdog (active low)
   localparam int OPT_WD_BIT = 2;
   // Control register bits
   localparam int CTL_HALT_BIT = 0;
   localparam int CTL_IDLE_BIT = 1;
   localparam int CTL_BOOT_BIT = 2;
   // Window limits in idle-timer clocks
   localparam logic [16:0] WIN_LOWER = 17'h00800;
   localparam logic [16:0] WIN_8K = 17'h02000;
   // Fault stretch after pin falls, 16 to 32 cycles
   localparam int STRETCH_CYC = 24;
   localparam logic [4:0] STRETCH_MAX = 5'(STRETCH_CYC - 1);
   // Clock monitor: tick gap limit in system clocks
   localparam int CLK_HZ = 20000000;
   localparam int CM_MIN_HZ = 1000;
   localparam int CM_LIMIT_CYC = CLK_HZ / CM_MIN_HZ;
   // Idle timer width and tick select reset value
   localparam int IT_W = 16;
   localparam logic [2:0] TSEL_RST = 3'h0;

   typedef struct packed {
      logic [1:0] win;
      logic cm_en;
      logic done;
   } wwd_cfg_s;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wwd_bus_s;

   typedef enum logic [1:0] {ST_IDLE, ST_PULL, ST_STRETCH, ST_WAITHI} wwd_flt_e;

   function automatic logic [16:0] upper_limit(input logic [1:0] win);
      upper_limit = WIN_8K << win;
   endfunction
endpackage

// ---- wwd_idle_timer.sv ----
// Free-running idle timer with a selectable-bit tick pending flag.
// Assumes the timer is not cleared by reset, only by power-on state.
`timescale 1ns/1ps
module wwd_idle_timer #(
   parameter int W = wwd_pkg::IT_W
) (
   input wire logic i_mclk,        // system clock
   input wire logic i_rstn,        // async reset, active low
   input wire logic i_tick_en,     // idle-timer clock enable pulse
   input wire logic [2:0] i_tsel,  // 0..4 selects 4k..64k
   input wire logic i_pnd_clr,     // software clear of pending flag
   output logic o_tick,            // one idle-timer clock
   output logic o_pnd              // idle tick pending flag
);
   // Power-on value only; external reset leaves the count running
   logic [W-1:0] cnt_r = '0;
   logic [W-1:0] cnt_nxt;
   logic pnd_r;
   logic pnd_nxt;
   logic [W:0] cur;
   logic [W:0] inc;
   logic [4:0] bsel;

   always_comb
   begin
      bsel = 5'(5'd12 + {2'b00, i_tsel});
      cur = {1'b0, cnt_r};
      inc = cur + (W+1)'(1);
      cnt_nxt = i_tick_en ? inc[W-1:0] : cnt_r;
      pnd_nxt = pnd_r;
      if (i_pnd_clr)
         pnd_nxt = 1'b0;
      // The carry stands in for bit W, so the longest period still has a toggle
      if (i_tick_en && (inc[bsel] != cur[bsel]))
         pnd_nxt = 1'b1;
   end

   // Counter has no reset: external reset leaves it running
   always_ff @(posedge i_mclk)
   begin
      cnt_r <= cnt_nxt;
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
         pnd_r <= 1'b0;
      else
         pnd_r <= pnd_nxt;
   end

   assign o_tick = i_tick_en;
   assign o_pnd = pnd_r;
endmodule

// ---- wwd_clk_mon.sv ----
// Clock monitor: flags an error when instruction clock pulses stop.
// Assumes i_tc is a one-cycle pulse per instruction clock.
`timescale 1ns/1ps
module wwd_clk_mon #(
   parameter int LIMIT = wwd_pkg::CM_LIMIT_CYC
) (
   input wire logic i_mclk,   // system clock
   input wire logic i_rstn,   // async reset, active low
   input wire logic i_tc,     // instruction clock pulse
   output logic o_err         // clock too slow
);
   logic [15:0] gap_r;
   logic [15:0] gap_nxt;
   logic err_r;
   logic err_nxt;

   always_comb
   begin
      gap_nxt = gap_r;
      if (i_tc)
         gap_nxt = '0;
      else if (gap_r != 16'(LIMIT))
         gap_nxt = gap_r + 16'h1;
      // Gap starts at zero: a fast clock is never flagged while starting,
      // a dead oscillator trips once the gap reaches the limit
      err_nxt = (gap_nxt == 16'(LIMIT));
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         gap_r <= '0;
         err_r <= 1'b0;
      end
      else
      begin
         gap_r <= gap_nxt;
         err_r <= err_nxt;
      end
   end

   assign o_err = err_r;
endmodule

// ---- wwd_top.sv ----
// Windowed watchdog with key-protected service register and clock monitor.
// Assumes the core drives a one-cycle register port and instruction/idle pulses.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
module wwd_top #(
   parameter int CM_LIMIT = wwd_pkg::CM_LIMIT_CYC
) (
   input wire logic i_mclk,          // 20 MHz clock
   input wire logic i_rstn,          // async reset, active low
   input wire logic [7:0] i_option,  // option byte
   input wire logic [1:0] i_addr,    // register address
   input wire logic [7:0] i_wdata,   // write data
   input wire logic i_wr,            // write strobe
   input wire logic i_rd,            // read strobe
   input wire logic i_tc,            // instruction clock pulse
   input wire logic i_it_clk,        // idle-timer clock pulse
   input wire logic i_pin,           // shared fault pin level
   output logic [7:0] o_rdata,       // read data, cycle after strobe
   output logic o_fault_output_low,  // pin output value (always 0)
   output logic o_pin_oe,            // pin driven low while high
   output logic o_wd_en,             // pin in watchdog mode, weak pull-up
   output logic o_idle_tick_pending  // idle tick pending flag
);
   wwd_pkg::wwd_bus_s bus;
   wwd_pkg::wwd_cfg_s cfg_r;
   wwd_pkg::wwd_cfg_s cfg_nxt;
   wwd_pkg::wwd_flt_e flt_r;
   wwd_pkg::wwd_flt_e flt_nxt;
   logic [16:0] cnt_r;
   logic [16:0] cnt_nxt;
   logic lower_on_r;
   logic lower_on_nxt;
   logic [4:0] str_r;
   logic [4:0] str_nxt;
   logic [4:0] cmh_r;
   logic [4:0] cmh_nxt;
   logic cm_hold_r;
   logic cm_hold_nxt;
   logic [2:0] ctl_r;
   logic [2:0] ctl_nxt;
   logic [2:0] tsel_r;
   logic [2:0] tsel_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic oe_r;
   logic oe_nxt;
   logic wd_en_r;
   logic wd_en_nxt;
   logic pnd_r;
   logic cm_err;
   logic it_tick;
   logic it_pnd;
   logic pnd_clr;
   logic svc_wr;
   logic match;
   logic early;
   logic late;
   logic wd_err;
   logic halted;
   logic idle;
   logic boot;
   logic leave_halt;
   logic leave_idle;
   logic boot_edge;

   assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
   assign halted = ctl_r[wwd_pkg::CTL_HALT_BIT];
   assign idle = ctl_r[wwd_pkg::CTL_IDLE_BIT];
   assign boot = ctl_r[wwd_pkg::CTL_BOOT_BIT];
   assign pnd_clr = bus.wr && (bus.addr == wwd_pkg::ADDR_STS) && bus.wdata[0];

   wwd_idle_timer #(
      .W(wwd_pkg::IT_W)
   ) u_it (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_tick_en(i_it_clk),
      .i_tsel(tsel_r),
      .i_pnd_clr(pnd_clr),
      .o_tick(it_tick),
      .o_pnd(it_pnd)
   );

   wwd_clk_mon #(
      .LIMIT(CM_LIMIT)
   ) u_cm (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_tc(i_tc),
      .o_err(cm_err)
   );

   // Control register writes and their edges
   always_comb
   begin
      ctl_nxt = ctl_r;
      tsel_nxt = tsel_r;
      if (bus.wr && bus.addr == wwd_pkg::ADDR_CTL)
         ctl_nxt = bus.wdata[2:0];
      if (bus.wr && bus.addr == wwd_pkg::ADDR_TSEL)
         tsel_nxt = (bus.wdata[2:0] > 3'h4) ? 3'h4 : bus.wdata[2:0];
      leave_halt = halted && !ctl_nxt[wwd_pkg::CTL_HALT_BIT];
      leave_idle = idle && !ctl_nxt[wwd_pkg::CTL_IDLE_BIT];
      boot_edge = boot != ctl_nxt[wwd_pkg::CTL_BOOT_BIT];
   end

   // Service check
   always_comb
   begin
      svc_wr = bus.wr && (bus.addr == wwd_pkg::ADDR_SVC) && (flt_r == wwd_pkg::ST_IDLE);
      match = (bus.wdata[5:1] == wwd_pkg::SVC_KEY);
      if (cfg_r.done)
      begin
         match = match && (bus.wdata[7:6] == cfg_r.win)
            && (bus.wdata[0] == cfg_r.cm_en);
      end
      // Lower window off until first service, and during boot code
      early = cfg_r.done && lower_on_r && (cnt_r < wwd_pkg::WIN_LOWER);
      late = (cnt_r >= wwd_pkg::upper_limit(cfg_r.win));
      wd_err = wd_en_r && ((svc_wr && (!match || early))
         || (late && !halted && !idle));
   end

   // Configuration, window counter and lower-window enable
   always_comb
   begin
      cfg_nxt = cfg_r;
      cnt_nxt = cnt_r;
      lower_on_nxt = lower_on_r;
      if (it_tick && !halted && !idle && cnt_r != 17'h1ffff)
         cnt_nxt = cnt_r + 17'h1;
      if (svc_wr && match && !early)
      begin
         cnt_nxt = '0;
         if (!cfg_r.done)
         begin
            cfg_nxt.win = bus.wdata[7:6];
            cfg_nxt.cm_en = bus.wdata[0];
            cfg_nxt.done = 1'b1;
         end
      end
      if (boot_edge)
      begin
         cnt_nxt = '0;
         lower_on_nxt = !ctl_nxt[wwd_pkg::CTL_BOOT_BIT];
      end
      if (leave_halt || leave_idle)
         cnt_nxt = '0;
      if (flt_r == wwd_pkg::ST_WAITHI && i_pin)
         cnt_nxt = '0;
   end

   // Fault pin sequencer
   always_comb
   begin
      flt_nxt = flt_r;
      str_nxt = str_r;
      unique case (flt_r)
         wwd_pkg::ST_IDLE:
            if (wd_err)
               flt_nxt = wwd_pkg::ST_PULL;
         wwd_pkg::ST_PULL:
            if (!i_pin)
            begin
               flt_nxt = wwd_pkg::ST_STRETCH;
               str_nxt = '0;
            end
         wwd_pkg::ST_STRETCH:
            if (str_r == wwd_pkg::STRETCH_MAX)
               flt_nxt = wwd_pkg::ST_WAITHI;
            else
               str_nxt = str_r + 5'h1;
         wwd_pkg::ST_WAITHI:
            if (i_pin)
               flt_nxt = wwd_pkg::ST_IDLE;
      endcase
   end

   // Clock error hold: the pin stays low for a stretch after the clock recovers
   always_comb
   begin
      cm_hold_nxt = cm_hold_r;
      cmh_nxt = cmh_r;
      if (cfg_r.cm_en && cm_err)
      begin
         cm_hold_nxt = 1'b1;
         cmh_nxt = '0;
      end
      else if (cm_hold_r)
      begin
         if (cmh_r == wwd_pkg::STRETCH_MAX)
            cm_hold_nxt = 1'b0;
         else
            cmh_nxt = cmh_r + 5'h1;
      end
   end

   // Pin drive and read-back
   always_comb
   begin
      wd_en_nxt = !i_option[wwd_pkg::OPT_WD_BIT];
      // Gated by the next enable so the drive never outlives watchdog mode
      oe_nxt = wd_en_nxt && ((flt_nxt == wwd_pkg::ST_PULL) || (flt_nxt == wwd_pkg::ST_STRETCH)
         || cm_hold_nxt);
      rdata_nxt = 8'h00;
      if (bus.rd)
      begin
         unique case (bus.addr)
            wwd_pkg::ADDR_SVC:
               rdata_nxt = {cfg_r.win, 5'h00, cfg_r.cm_en};
            wwd_pkg::ADDR_CTL:
               rdata_nxt = {5'h00, ctl_r};
            wwd_pkg::ADDR_STS:
               rdata_nxt = {4'h0, cm_err, oe_r, cfg_r.done, it_pnd};
            wwd_pkg::ADDR_TSEL:
               rdata_nxt = {5'h00, tsel_r};
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cfg_r <= '{win: wwd_pkg::SVC_WIN_RST, cm_en: wwd_pkg::SVC_CM_RST, done: 1'b0};
         cnt_r <= '0;
         lower_on_r <= 1'b1;
         flt_r <= wwd_pkg::ST_IDLE;
         str_r <= '0;
         cmh_r <= '0;
         cm_hold_r <= 1'b0;
         ctl_r <= '0;
         tsel_r <= wwd_pkg::TSEL_RST;
         rdata_r <= '0;
         oe_r <= 1'b0;
         wd_en_r <= 1'b0;
         pnd_r <= 1'b0;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         cnt_r <= cnt_nxt;
         lower_on_r <= lower_on_nxt;
         flt_r <= flt_nxt;
         str_r <= str_nxt;
         cmh_r <= cmh_nxt;
         cm_hold_r <= cm_hold_nxt;
         ctl_r <= ctl_nxt;
         tsel_r <= tsel_nxt;
         rdata_r <= rdata_nxt;
         oe_r <= oe_nxt;
         wd_en_r <= wd_en_nxt;
         pnd_r <= it_pnd;
      end
   end

   assign o_rdata = rdata_r;
   assign o_fault_output_low = 1'b0;
   assign o_pin_oe = oe_r;
   assign o_wd_en = wd_en_r;
   assign o_idle_tick_pending = pnd_r;
endmodule

// ---- wwd_rst_ckt.sv ----
// Model of the external reset circuit hanging on the shared fault pin.
// Assumes a weak pull-up on the pin and a load that may slow its fall.
`timescale 1ns/1ps
module wwd_rst_ckt (
   input wire logic i_mclk,  // system clock
   input wire logic i_oe,    // device pulls the pin low
   input wire logic i_slow,  // heavy load, pin falls three cycles late
   output logic o_pin        // pin level seen by the device
);
   logic [1:0] dly_r = 2'h0;
   logic [1:0] dly_nxt;
   always_comb
   begin
      dly_nxt = 2'h0;
      if (i_oe && dly_r != 2'h3)
      begin
         dly_nxt = dly_r + 2'h1;
      end
      else if (i_oe)
      begin
         dly_nxt = dly_r;
      end
   end
   always_ff @(posedge i_mclk)
   begin
      dly_r <= dly_nxt;
   end
   // Pull-up wins as soon as the device lets go
   assign o_pin = !(i_oe && (!i_slow || dly_r == 2'h3));
endmodule

// ---- wwd_top_asserts.sv ----
// Port-level checker for the watchdog top, bound into every instance.
// Assumes the far side pulls the pin high whenever it is released.
`timescale 1ns/1ps
module wwd_top_asserts #(
   parameter int CM_LIMIT = wwd_pkg::CM_LIMIT_CYC
) (
   input wire logic i_mclk,          // clock
   input wire logic i_rstn,          // async reset, active low
   input wire logic [7:0] i_option,  // option byte
   input wire logic [1:0] i_addr,    // register address
   input wire logic [7:0] i_wdata,   // write data
   input wire logic i_wr,            // write strobe
   input wire logic i_rd,            // read strobe
   input wire logic i_tc,            // instruction clock pulse
   input wire logic i_it_clk,        // idle-timer pulse
   input wire logic i_pin,           // pin level
   input wire logic [7:0] o_rdata,   // read data
   input wire logic o_fault_output_low,  // pin value
   input wire logic o_pin_oe,        // pin pulled low
   input wire logic o_wd_en,         // watchdog mode
   input wire logic o_idle_tick_pending  // pending flag
);
   logic [7:0] lo_r, lo_nxt;
   logic [15:0] gap_r, gap_nxt;
   logic slow_r, slow_nxt;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   // A slow clock excuses long holds, since the monitor keeps the pin low
   always_comb
   begin
      lo_nxt = (o_pin_oe && !i_pin) ? lo_r + {7'h00, lo_r != 8'hff} : 8'h00;
      gap_nxt = i_tc ? 16'h0000 : gap_r + {15'h0000, gap_r != 16'hffff};
      slow_nxt = (32'(gap_r) > CM_LIMIT) ? 1'b1 : (o_pin_oe ? slow_r : 1'b0);
   end
   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         lo_r <= 8'h00;
         gap_r <= 16'h0000;
         slow_r <= 1'b1;
      end
      else
      begin
         lo_r <= lo_nxt;
         gap_r <= gap_nxt;
         slow_r <= slow_nxt;
      end
   end
   a_rd_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside read");
   a_key_hidden: assert property ($past(i_rd) && $past(i_addr) == wwd_pkg::ADDR_SVC
      |-> o_rdata[5:1] == 5'h00) else $error("key field readable");
   a_wd_en_opt: assert property ($past(i_rstn)
      |-> o_wd_en == !$past(i_option[wwd_pkg::OPT_WD_BIT])) else $error("wd enable wrong");
   a_out_low: assert property (o_fault_output_low == 1'b0)
      else $error("pin drive value not low");
   a_stretch_min: assert property ($fell(o_pin_oe) && !slow_r |-> lo_r >= 8'd16)
      else $error("pin released too soon");
   a_stretch_max: assert property (!slow_r |-> lo_r <= 8'd33)
      else $error("pin held too long");
   a_bad_key: assert property (i_wr && i_addr == wwd_pkg::ADDR_SVC && o_wd_en && i_pin
      && i_wdata[5:1] != wwd_pkg::SVC_KEY && !o_pin_oe && !$past(o_pin_oe)
      && !$past(o_pin_oe, 2) |-> ##2 o_pin_oe) else $error("bad key not flagged");
   a_rst_quiet: assert property ($rose(i_rstn) |-> !o_pin_oe && !o_wd_en)
      else $error("outputs active in reset");
   a_oe_needs_en: assert property (o_pin_oe |-> o_wd_en)
      else $error("pin driven while disabled");
endmodule
bind wwd_top wwd_top_asserts #(.CM_LIMIT(CM_LIMIT)) wwd_top_asserts_inst (
   .i_mclk(i_mclk), .i_rstn(i_rstn), .i_option(i_option), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_tc(i_tc), .i_it_clk(i_it_clk),
   .i_pin(i_pin), .o_rdata(o_rdata), .o_fault_output_low(o_fault_output_low),
   .o_pin_oe(o_pin_oe), .o_wd_en(o_wd_en), .o_idle_tick_pending(o_idle_tick_pending));

// ---- tb.sv ----
// Self-checking bench for the watchdog top with the reset-circuit model.
// Assumes a short clock-monitor limit so clock loss shows within 50 cycles.
`timescale 1ns/1ps
module tb;
   logic i_mclk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_tc = 1'b0;
   logic i_it_clk = 1'b1, i_pin, slow = 1'b0, tc_run = 1'b1;
   logic [7:0] i_option = 8'h00, i_wdata = 8'h00, o_rdata, d;
   logic [1:0] i_addr = 2'h0;
   logic o_fault_output_low, o_pin_oe, o_wd_en, o_idle_tick_pending;
   logic [3:0] div = 4'h0;
   int n_mismatch = 0, checks_done = 0, c;
   always #25 i_mclk = ~i_mclk;
   always @(posedge i_mclk)
   begin
      div <= (div == 4'h9) ? 4'h0 : div + 4'h1;
      i_tc <= tc_run && (div == 4'h0);
   end
   wwd_top #(.CM_LIMIT(50)) wwd_top_inst (.i_mclk(i_mclk), .i_rstn(i_rstn),
      .i_option(i_option), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .i_tc(i_tc), .i_it_clk(i_it_clk), .i_pin(i_pin), .o_rdata(o_rdata),
      .o_fault_output_low(o_fault_output_low), .o_pin_oe(o_pin_oe), .o_wd_en(o_wd_en),
      .o_idle_tick_pending(o_idle_tick_pending));
   wwd_rst_ckt wwd_rst_ckt_inst (.i_mclk(i_mclk), .i_oe(o_pin_oe), .i_slow(slow),
      .o_pin(i_pin));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   // Looks for the pin drive high at any clock edge within n cycles
   task automatic fault(input int n, input logic e);
      logic h;
      h = 1'b0;
      repeat (n) @(posedge i_mclk) h = h | (o_pin_oe === 1'b1);
      chk("fault", {7'h00, e}, {7'h00, h});
   endtask
   task automatic recover;
      c = 0;
      while (o_pin_oe !== 1'b0 && c < 200) @(posedge i_mclk) c++;
      chk("released", 8'h00, {7'h00, o_pin_oe});
      repeat (3) @(posedge i_mclk);
   endtask
   task automatic t_start;
      fault(100, 1'b0);
      chk("wd_en", 8'h01, {7'h00, o_wd_en});
      rd(wwd_pkg::ADDR_SVC);
      chk("svc reset", 8'hc1, d);
      wr(wwd_pkg::ADDR_SVC, 8'h19);
      rd(wwd_pkg::ADDR_SVC);
      chk("svc cfg", 8'h01, d);
      fault(50, 1'b0);
   endtask
   task automatic t_early;
      slow <= 1'b1;
      wr(wwd_pkg::ADDR_SVC, 8'h19);
      fault(5, 1'b1);
      wr(wwd_pkg::ADDR_SVC, 8'h1b);
      recover();
      chk("stretch", 8'h01, {7'h00, c >= 17 && c <= 40});
      slow <= 1'b0;
      fault(100, 1'b0);
   endtask
   task automatic t_fields;
      logic [7:0] bad [3] = '{8'h18, 8'h59, 8'h1b};
      repeat (2100) @(posedge i_mclk);
      wr(wwd_pkg::ADDR_SVC, 8'h19);
      fault(50, 1'b0);
      foreach (bad[i])
      begin
         repeat (2100) @(posedge i_mclk);
         wr(wwd_pkg::ADDR_SVC, bad[i]);
         fault(5, 1'b1);
         recover();
      end
      fault(8000, 1'b0);
      fault(400, 1'b1);
      recover();
   endtask
   task automatic t_modes;
      repeat (2100) @(posedge i_mclk);
      wr(wwd_pkg::ADDR_CTL, 8'h02);
      fault(9000, 1'b0);
      wr(wwd_pkg::ADDR_CTL, 8'h00);
      wr(wwd_pkg::ADDR_SVC, 8'h19);
      fault(5, 1'b1);
      recover();
      wr(wwd_pkg::ADDR_CTL, 8'h04);
      wr(wwd_pkg::ADDR_SVC, 8'h19);
      fault(50, 1'b0);
      wr(wwd_pkg::ADDR_CTL, 8'h00);
      wr(wwd_pkg::ADDR_SVC, 8'h19);
      fault(5, 1'b1);
      recover();
   endtask
   task automatic t_clk_pend;
      repeat (2100) @(posedge i_mclk);
      wr(wwd_pkg::ADDR_CTL, 8'h01);
      tc_run <= 1'b0;
      fault(200, 1'b1);
      tc_run <= 1'b1;
      recover();
      chk("cm hold", 8'h01, {7'h00, c >= 17 && c <= 45});
      wr(wwd_pkg::ADDR_CTL, 8'h00);
      wr(wwd_pkg::ADDR_SVC, 8'h19);
      fault(5, 1'b1);
      recover();
      wr(wwd_pkg::ADDR_TSEL, 8'h00);
      wr(wwd_pkg::ADDR_STS, 8'h01);
      repeat (3) @(posedge i_mclk);
      chk("pend clr", 8'h00, {7'h00, o_idle_tick_pending});
      c = 0;
      while (o_idle_tick_pending !== 1'b1 && c < 4200) @(posedge i_mclk) c++;
      chk("pend set", 8'h01, {7'h00, o_idle_tick_pending});
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_mclk);
      chk("rst oe", 8'h00, {7'h00, o_pin_oe});
      i_rstn <= 1'b1;
      rd(wwd_pkg::ADDR_SVC);
      chk("svc rearm", 8'hc1, d);
      i_option <= 8'h04;
      repeat (2) @(posedge i_mclk);
      chk("wd_en off", 8'h00, {7'h00, o_wd_en});
   endtask
   initial
   begin
      repeat (50000) @(posedge i_mclk);
      n_mismatch++;
      stop_test();
   end
   initial
   begin
      repeat (2) @(posedge i_mclk);
      i_rstn <= 1'b1;
      t_start();
      t_early();
      t_fields();
      t_modes();
      t_clk_pend();
      stop_test();
   end
endmodule
